//--- pkg/scep_pkg.sv
// Shared constants, field layouts and enumerations of the serial command and event port
package scep_pkg;
  // Register word geometry
  localparam int DATA_W = 24;
  localparam int IDX_W = 5;
  localparam int REG_COUNT = 32;
  // Register indices held in the port itself
  localparam logic [4:0] IDX_CONFIG = 5'h00;
  localparam logic [4:0] IDX_STATUS = 5'h0F;
  localparam logic [4:0] IDX_MASK = 5'h1A;
  // Configuration fields
  localparam int CFG_K_LSB = 0;
  localparam int CFG_POL_INV_BIT = 4;
  localparam int CFG_PULSE_SEL_BIT = 5;
  localparam logic [23:0] CFG_RESET = 24'h00_0001;
  localparam logic [23:0] STATUS_RESET = 24'h00_0000;
  localparam logic [23:0] MASK_RESET = 24'h00_0000;
  localparam int STS_READY_BIT = 23;
  // Command bytes and fields
  localparam logic [7:0] CMD_SYNC_FILL = 8'hFF;
  localparam logic [7:0] CMD_SYNC_TERM = 8'hFE;
  localparam logic [7:0] CMD_POWER_UP = 8'hA0;
  localparam logic [7:0] CMD_START_SINGLE = 8'hE0;
  localparam logic [7:0] CMD_START_CONT = 8'hE8;
  localparam logic [2:0] CMD_PD_TOP = 3'h4;
  localparam logic [1:0] PD_SW_RESET = 2'h0;
  localparam logic [1:0] PD_STANDBY = 2'h1;
  localparam logic [1:0] PD_SLEEP = 2'h2;
  // Timing counts
  localparam logic [3:0] XTAL_SETTLE_PERIODS = 4'h8;
  localparam logic [1:0] SYNC_MIN_FILL = 2'h3;
  localparam logic [1:0] WRITE_DATA_BYTES = 2'h3;
  localparam logic [1:0] IRQ_PULSE_TICKS = 2'h2;
  // Power states
  typedef enum logic [1:0] {
    PWR_INIT = 2'b00,
    PWR_ACTIVE = 2'b01,
    PWR_STANDBY = 2'b10,
    PWR_SLEEP = 2'b11
  } scep_power_t;
  // Command classes
  typedef enum logic [2:0] {
    CK_INVALID = 3'b000,
    CK_READ = 3'b001,
    CK_WRITE = 3'b010,
    CK_SYNC_FILL = 3'b011,
    CK_SYNC_TERM = 3'b100,
    CK_INSTR = 3'b101
  } scep_cmd_t;
endpackage

//--- rtl/scep_reg_mem.sv
// Register storage for the words not held in the port itself, with a bulk clear
`timescale 1ns/1ps
module scep_reg_mem #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic clear,
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrIdx,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [$clog2(DEPTH)-1:0] rdIdx,
  output logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH-1:0] validQ;

  initial
  begin
    if (DEPTH < 2 || WIDTH < 1)
      $error("scep_reg_mem: unsupported geometry");
  end

  // Array storage, no reset so it maps to plain memory
  always_ff @(posedge clk)
  begin
    if (clkEn && wrEn)
      mem[wrIdx] <= wrData;
  end

  // Valid bits make a clear cost one cycle instead of a sweep
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      validQ <= '0;
    else if (clkEn)
    begin
      if (clear)
        validQ <= '0;
      else if (wrEn)
        validQ[wrIdx] <= 1'b1;
    end
  end

  // Registered read, a cleared word reads as its zero default
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdData <= '0;
    else if (clkEn)
      rdData <= validQ[rdIdx] ? mem[rdIdx] : '0;
  end
endmodule

//--- rtl/scep_core.sv
// Serial command port, power sequencing, clock divider and event handler
`timescale 1ns/1ps
// Operation
// - After power-on release, wait eight crystal periods before initialising.
// - Reset pin is asynchronous; after release wait eight crystal periods again.
// - Command 0x80 returns every register, pin drivers too, to defaults.
// - Ready flag sets once active after reset or initialisation.
// - Stand-by keeps oscillator; power-up returns to active without initialisation.
// - Sleep keeps only decoder; power-up runs full initialisation with settling delay. Here the divided clock keeps running in sleep at ratio one.
// - Master clock is crystal clock divided by four-bit configuration ratio.
// - Status bit drives interrupt only when its mask bit is one.
// - Writing one clears a status bit; writing zero leaves it.
// - Pulse-select and invert choose low level, high level, low or high pulse.
// - Interrupt pulse lasts at least one divided clock cycle.
// - Each received byte is a command: instruction, sync, write or read.
// - New instruction aborts running instruction, not read data in flight.
// - Sync bytes affect only the serial interface state.
// - Write commands take three data bytes; reads return register data bytes.
// - Commands and data shift most significant bit first.
// - Commands accepted during read-out; a new read ends the current read.
// - Serial clock edges count only while select is asserted.
// - Port re-initialises on select high-then-low, reset pin, or sync sequence.
// - Access byte is 0, write bit, five-bit index, 0; write lands at 24th clock.
// - Power-down field: reset, stand-by, sleep, reserved.
// - Power-up command restarts a powered-down device, otherwise halts computation.
module scep_core #(
  parameter int DATA_W = 24,
  parameter int REG_COUNT = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic crystalInputClock,
  input wire logic chipSelect_n,
  input wire logic serialClock,
  input wire logic serialIn,
  input wire logic [DATA_W-1:0] eventIn,
  output logic serialOut,
  output logic irqPin,
  output logic dividedClock,
  output logic readyFlag,
  output logic computeRun,
  output logic computeContinuous,
  output logic powerStandby,
  output logic powerSleep
);
  localparam int IW = $clog2(REG_COUNT);

  initial
  begin
    if (DATA_W != scep_pkg::DATA_W || REG_COUNT != scep_pkg::REG_COUNT)
      $error("scep_core: register geometry must match the command format");
  end

  // Byte classification, used by the decoder only
  function automatic scep_pkg::scep_cmd_t cmdKind(input logic [7:0] b);
    if (b == scep_pkg::CMD_SYNC_FILL)
      return scep_pkg::CK_SYNC_FILL;
    else if (b == scep_pkg::CMD_SYNC_TERM)
      return scep_pkg::CK_SYNC_TERM;
    else if (!b[7] && !b[0])
      return b[6] ? scep_pkg::CK_WRITE : scep_pkg::CK_READ;
    else if (b == scep_pkg::CMD_POWER_UP || b == scep_pkg::CMD_START_SINGLE || b == scep_pkg::CMD_START_CONT)
      return scep_pkg::CK_INSTR;
    else if (b[7:5] == scep_pkg::CMD_PD_TOP && b[2:0] == 3'h0 && b[4:3] != 2'h3)
      return scep_pkg::CK_INSTR;
    else
      return scep_pkg::CK_INVALID;
  endfunction

  // Three-stage pin synchronisers; a change counts once stages two and three agree
  logic [3:0] syncS1Q, syncS2Q, syncS3Q, pinQ;
  logic [3:0] pinRise, pinFall;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Idle levels, select high, so no false select edge follows reset
      syncS1Q <= 4'h2;
      syncS2Q <= 4'h2;
      syncS3Q <= 4'h2;
      pinQ <= 4'h2;
    end
    else if (clkEn)
    begin
      syncS1Q <= {serialIn, serialClock, chipSelect_n, crystalInputClock};
      syncS2Q <= syncS1Q;
      syncS3Q <= syncS2Q;
      pinQ <= (~(syncS2Q ^ syncS3Q) & syncS3Q) | ((syncS2Q ^ syncS3Q) & pinQ);
    end
  end
  assign pinRise = ~(syncS2Q ^ syncS3Q) & syncS3Q & ~pinQ;
  assign pinFall = ~(syncS2Q ^ syncS3Q) & ~syncS3Q & pinQ;

  logic xtalRise, csHigh, csRise, sclkRise, sclkFall, serialInLevel;
  assign xtalRise = pinRise[0];
  assign csHigh = pinQ[1];
  assign csRise = pinRise[1];
  assign sclkRise = pinRise[2] & ~csHigh;
  assign sclkFall = pinFall[2] & ~csHigh;
  assign serialInLevel = pinQ[3];

  // Held control registers and power state
  logic [DATA_W-1:0] configQ, statusQ, maskQ;
  scep_pkg::scep_power_t powerQ;
  logic [3:0] settleCntQ;
  logic swResetEv, powerUpEv, standbyEv, sleepEv, startEv, regWriteEv;
  logic [IW-1:0] regWriteIdx;
  logic [DATA_W-1:0] regWriteData;
  logic [7:0] cmdByte;

  // Power sequencing: initialisation waits eight crystal periods in every entry path
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      powerQ <= scep_pkg::PWR_INIT;
      settleCntQ <= 4'h0;
    end
    else if (clkEn)
    begin
      case (powerQ)
        scep_pkg::PWR_INIT:
        begin
          if (swResetEv)
            settleCntQ <= 4'h0;
          else if (settleCntQ == scep_pkg::XTAL_SETTLE_PERIODS)
            powerQ <= scep_pkg::PWR_ACTIVE;
          else if (xtalRise)
            settleCntQ <= settleCntQ + 4'h1;
        end
        scep_pkg::PWR_ACTIVE, scep_pkg::PWR_STANDBY, scep_pkg::PWR_SLEEP:
        begin
          if (swResetEv || (powerUpEv && powerQ == scep_pkg::PWR_SLEEP))
          begin
            powerQ <= scep_pkg::PWR_INIT;
            settleCntQ <= 4'h0;
          end
          else if (powerUpEv)
            powerQ <= scep_pkg::PWR_ACTIVE;
          else if (standbyEv)
            powerQ <= scep_pkg::PWR_STANDBY;
          else if (sleepEv)
            powerQ <= scep_pkg::PWR_SLEEP;
        end
        default:
          powerQ <= scep_pkg::PWR_INIT;
      endcase
    end
  end

  logic enterActive;
  assign enterActive = powerQ == scep_pkg::PWR_INIT && settleCntQ == scep_pkg::XTAL_SETTLE_PERIODS && !swResetEv;

  // Computation control; any instruction first aborts what runs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      computeRun <= 1'b0;
      computeContinuous <= 1'b0;
    end
    else if (clkEn && (swResetEv || powerUpEv || standbyEv || sleepEv || startEv))
    begin
      computeRun <= startEv && powerQ == scep_pkg::PWR_ACTIVE;
      computeContinuous <= startEv && powerQ == scep_pkg::PWR_ACTIVE && cmdByte[3];
    end
  end

  // Configuration and mask: software written, defaulted by software reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      configQ <= scep_pkg::CFG_RESET;
      maskQ <= scep_pkg::MASK_RESET;
    end
    else if (clkEn)
    begin
      if (swResetEv)
      begin
        configQ <= scep_pkg::CFG_RESET;
        maskQ <= scep_pkg::MASK_RESET;
      end
      else if (regWriteEv && regWriteIdx == scep_pkg::IDX_CONFIG)
        configQ <= regWriteData;
      else if (regWriteEv && regWriteIdx == scep_pkg::IDX_MASK)
        maskQ <= regWriteData;
    end
  end

  // Status: sticky events, write-one-to-clear, a new event wins over its clear
  logic [DATA_W-1:0] statusSet, statusClr, statusD;
  assign statusSet = (eventIn & ~(DATA_W'(1) << scep_pkg::STS_READY_BIT))
    | (DATA_W'(enterActive) << scep_pkg::STS_READY_BIT);
  assign statusClr = (regWriteEv && regWriteIdx == scep_pkg::IDX_STATUS) ? regWriteData : '0;
  assign statusD = (statusQ & ~statusClr) | statusSet;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      statusQ <= scep_pkg::STATUS_RESET;
    else if (clkEn)
      statusQ <= swResetEv ? scep_pkg::STATUS_RESET : statusD;
  end

  // Crystal divider; the divided clock stops only in sleep, and there only for ratios above one
  logic [3:0] kEff, divCntQ;
  logic dividedTick;
  assign kEff = (configQ[scep_pkg::CFG_K_LSB +: 4] == 4'h0) ? 4'h1 : configQ[scep_pkg::CFG_K_LSB +: 4];
  assign dividedTick = xtalRise && powerQ != scep_pkg::PWR_SLEEP && divCntQ + 4'h1 >= kEff;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divCntQ <= 4'h0;
      dividedClock <= 1'b0;
    end
    else if (clkEn)
    begin
      if (xtalRise && powerQ != scep_pkg::PWR_SLEEP)
        divCntQ <= dividedTick ? 4'h0 : divCntQ + 4'h1;
      dividedClock <= (kEff == 4'h1) ? pinQ[0] : (divCntQ < (kEff >> 1));
    end
  end

  // Interrupt format; the pulse spans two tick boundaries so it covers a whole cycle
  logic irqLevel, irqNew, pulseQ, irqAsserted;
  logic [1:0] pulseTicksQ;
  assign irqLevel = |(statusQ & maskQ);
  assign irqNew = |(statusSet & maskQ & ~statusQ);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulseQ <= 1'b0;
      pulseTicksQ <= 2'h0;
    end
    else if (clkEn)
    begin
      if (swResetEv)
        pulseQ <= 1'b0;
      else if (irqNew)
      begin
        pulseQ <= 1'b1;
        pulseTicksQ <= 2'h0;
      end
      else if (pulseQ && dividedTick)
      begin
        pulseTicksQ <= pulseTicksQ + 2'h1;
        pulseQ <= pulseTicksQ + 2'h1 < scep_pkg::IRQ_PULSE_TICKS;
      end
    end
  end
  assign irqAsserted = configQ[scep_pkg::CFG_PULSE_SEL_BIT] ? pulseQ : irqLevel;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irqPin <= 1'b1;
    else if (clkEn)
      irqPin <= configQ[scep_pkg::CFG_POL_INV_BIT] ? irqAsserted : ~irqAsserted;
  end

  // Status outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      readyFlag <= 1'b0;
      powerStandby <= 1'b0;
      powerSleep <= 1'b0;
    end
    else if (clkEn)
    begin
      readyFlag <= statusQ[scep_pkg::STS_READY_BIT];
      powerStandby <= powerQ == scep_pkg::PWR_STANDBY;
      powerSleep <= powerQ == scep_pkg::PWR_SLEEP;
    end
  end

  // Receive side: bytes assembled MSB first on rising serial clock
  logic [7:0] rxShiftQ;
  logic [2:0] bitCntQ;
  logic [1:0] wrLeftQ, syncCntQ;
  logic [IW-1:0] wrIdxQ;
  logic [DATA_W-1:0] wrDataQ;
  logic byteDone, portReinit;
  scep_pkg::scep_cmd_t kind;
  assign cmdByte = {rxShiftQ[6:0], serialInLevel};
  assign byteDone = sclkRise && bitCntQ == 3'h7;
  assign kind = cmdKind(cmdByte);
  assign portReinit = csRise || (byteDone && wrLeftQ == 2'h0 && kind == scep_pkg::CK_SYNC_TERM
    && syncCntQ == scep_pkg::SYNC_MIN_FILL);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxShiftQ <= 8'h00;
      bitCntQ <= 3'h0;
      wrLeftQ <= 2'h0;
      syncCntQ <= 2'h0;
      wrIdxQ <= '0;
      wrDataQ <= '0;
    end
    else if (clkEn)
    begin
      if (portReinit)
      begin
        bitCntQ <= 3'h0;
        wrLeftQ <= 2'h0;
        syncCntQ <= 2'h0;
      end
      else if (sclkRise)
      begin
        rxShiftQ <= cmdByte;
        bitCntQ <= bitCntQ + 3'h1;
        if (wrLeftQ != 2'h0)
          wrDataQ <= {wrDataQ[DATA_W-2:0], serialInLevel};
        if (byteDone && wrLeftQ != 2'h0)
          wrLeftQ <= wrLeftQ - 2'h1;
        else if (byteDone)
        begin
          syncCntQ <= (kind != scep_pkg::CK_SYNC_FILL) ? 2'h0
            : (syncCntQ == scep_pkg::SYNC_MIN_FILL) ? syncCntQ : syncCntQ + 2'h1;
          if (kind == scep_pkg::CK_WRITE)
          begin
            wrLeftQ <= scep_pkg::WRITE_DATA_BYTES;
            wrIdxQ <= cmdByte[5:1];
          end
        end
      end
    end
  end

  // Command strobes, valid in the cycle the byte completes
  logic cmdPos, readEv;
  assign cmdPos = byteDone && wrLeftQ == 2'h0 && !csRise;
  assign readEv = cmdPos && kind == scep_pkg::CK_READ;
  assign startEv = cmdPos && (cmdByte == scep_pkg::CMD_START_SINGLE || cmdByte == scep_pkg::CMD_START_CONT);
  assign powerUpEv = cmdPos && cmdByte == scep_pkg::CMD_POWER_UP;
  assign swResetEv = cmdPos && kind == scep_pkg::CK_INSTR && cmdByte[7:5] == scep_pkg::CMD_PD_TOP
    && cmdByte[4:3] == scep_pkg::PD_SW_RESET;
  assign standbyEv = cmdPos && kind == scep_pkg::CK_INSTR && cmdByte[7:5] == scep_pkg::CMD_PD_TOP
    && cmdByte[4:3] == scep_pkg::PD_STANDBY;
  assign sleepEv = cmdPos && kind == scep_pkg::CK_INSTR && cmdByte[7:5] == scep_pkg::CMD_PD_TOP
    && cmdByte[4:3] == scep_pkg::PD_SLEEP;
  assign regWriteEv = byteDone && wrLeftQ == 2'h1 && !csRise;
  assign regWriteIdx = wrIdxQ;
  assign regWriteData = {wrDataQ[DATA_W-2:0], serialInLevel};

  // Word store for registers not held above
  logic [DATA_W-1:0] memRdData;
  logic localIdx;
  assign localIdx = regWriteIdx == scep_pkg::IDX_CONFIG || regWriteIdx == scep_pkg::IDX_STATUS
    || regWriteIdx == scep_pkg::IDX_MASK;
  scep_reg_mem #(.WIDTH(DATA_W), .DEPTH(REG_COUNT)) regMem (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .clear(swResetEv),
    .wrEn(regWriteEv && !localIdx),
    .wrIdx(regWriteIdx),
    .wrData(regWriteData),
    .rdIdx(cmdByte[5:1]),
    .rdData(memRdData)
  );

  // Transmit side: one-cycle read latency, then MSB first on falling serial clock
  logic rdPendQ;
  logic [IW-1:0] rdIdxQ;
  logic [DATA_W-1:0] txShiftQ, rdValue;
  always_comb
  begin
    case (rdIdxQ)
      scep_pkg::IDX_CONFIG: rdValue = configQ;
      scep_pkg::IDX_STATUS: rdValue = statusQ;
      scep_pkg::IDX_MASK: rdValue = maskQ;
      default: rdValue = memRdData;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdPendQ <= 1'b0;
      rdIdxQ <= '0;
      txShiftQ <= '0;
      serialOut <= 1'b0;
    end
    else if (clkEn)
    begin
      rdPendQ <= readEv;
      if (readEv)
        rdIdxQ <= cmdByte[5:1];
      if (csRise)
      begin
        txShiftQ <= '0;
        serialOut <= 1'b0;
      end
      else if (rdPendQ)
      begin
        serialOut <= rdValue[DATA_W-1];
        txShiftQ <= {rdValue[DATA_W-2:0], 1'b0};
      end
      else if (sclkFall)
      begin
        serialOut <= txShiftQ[DATA_W-1];
        txShiftQ <= {txShiftQ[DATA_W-2:0], 1'b0};
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  settle_wait_a: assert property (powerQ == scep_pkg::PWR_INIT && $past(powerQ) == scep_pkg::PWR_INIT
    |-> settleCntQ <= scep_pkg::XTAL_SETTLE_PERIODS) else $error("settle counter overran");
  ready_set_a: assert property (clkEn && enterActive |=> clkEn [*1] ##0 1'b1 |=> readyFlag || !clkEn)
    else $error("ready flag not raised after initialisation");
  sw_reset_a: assert property (clkEn && swResetEv |=> configQ == scep_pkg::CFG_RESET
    && maskQ == scep_pkg::MASK_RESET && powerQ == scep_pkg::PWR_INIT)
    else $error("software reset left state behind");
  sleep_wake_a: assert property (clkEn && powerUpEv && !swResetEv && powerQ == scep_pkg::PWR_SLEEP
    |=> powerQ == scep_pkg::PWR_INIT && settleCntQ == 4'h0) else $error("sleep wake skipped settling");
  // The pin is formed from the configuration of the previous cycle, so a config write may land meanwhile
  mask_gate_a: assert property (clkEn && !configQ[scep_pkg::CFG_PULSE_SEL_BIT] && !irqLevel
    |=> irqPin == !$past(configQ[scep_pkg::CFG_POL_INV_BIT])) else $error("masked status drove the interrupt");
  // Bits written one drop unless an event lands at once; bits written zero stay
  status_clear_a: assert property (clkEn && regWriteEv && regWriteIdx == scep_pkg::IDX_STATUS
    |=> (statusQ & $past(regWriteData) & ~$past(eventIn) & ~(DATA_W'(1) << scep_pkg::STS_READY_BIT)) == '0
    && ($past(statusQ) & ~$past(regWriteData) & ~statusQ) == '0) else $error("status write-one-clear wrong");
  level_hold_a: assert property (clkEn && !configQ[scep_pkg::CFG_PULSE_SEL_BIT] && irqLevel
    |=> irqPin == $past(configQ[scep_pkg::CFG_POL_INV_BIT])) else $error("level interrupt dropped");
  pulse_len_a: assert property (clkEn && irqNew && !swResetEv |=> pulseQ ##1 (pulseQ || $past(swResetEv)))
    else $error("interrupt pulse too short");
  write_land_a: assert property (clkEn && regWriteEv && regWriteIdx == scep_pkg::IDX_MASK
    |=> maskQ == $past(regWriteData)) else $error("write not landed at byte end");
endmodule

//--- tb/scep_host_model.sv
// Host-side model that drives the serial command port
`timescale 1ns/1ps
module scep_host_model (
  input wire logic clk,
  input wire logic serialOut,
  output logic chipSelect_n,
  output logic serialClock,
  output logic serialIn
);
  // Each serial phase spans HALF system clocks, well above the synchroniser delay
  localparam int HALF = 10;
  logic [31:0] rxHist = '0;
  initial
  begin
    chipSelect_n = 1'b1;
    serialClock = 1'b0;
    serialIn = 1'b1;
  end
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Serial clock stands still between frames; a released data line shows no stale value
  task automatic select(input logic on);
    wclk(HALF);
    chipSelect_n = !on;
    serialIn = !serialIn;
    wclk(HALF);
  endtask
  // Output sampled late in the high phase, once the port has driven it
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      serialIn = b[i];
      wclk(HALF);
      serialClock = 1'b1;
      wclk(HALF - 1);
      rxHist = {rxHist[30:0], serialOut};
      wclk(1);
      serialClock = 1'b0;
    end
  endtask
endmodule

//--- tb/serial_command_event_port_tb_top.sv
// Self-checking bench for the serial command and event port
`timescale 1ns/1ps
module serial_command_event_port_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic crystalInputClock = 1'b0;
  logic [23:0] eventIn = '0;
  logic chipSelect_n, serialClock, serialIn, serialOut, irqPin, readyFlag;
  logic computeRun, computeContinuous, powerStandby, powerSleep;
  logic [23:0] got, ev;
  logic [4:0] idx;
  int seed = 41019;
  int nMismatch = 0;
  int checkCount = 0;
  always #4 clk = ~clk;
  // 4 MHz crystal keeps the master clock in range with the reset divider
  always #125.3 crystalInputClock = ~crystalInputClock;
  scep_core i_dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .crystalInputClock(crystalInputClock),
    .chipSelect_n(chipSelect_n), .serialClock(serialClock), .serialIn(serialIn), .eventIn(eventIn),
    .serialOut(serialOut), .irqPin(irqPin), .dividedClock(), .readyFlag(readyFlag), .computeRun(computeRun),
    .computeContinuous(computeContinuous), .powerStandby(powerStandby), .powerSleep(powerSleep));
  scep_host_model host (.clk(clk), .serialOut(serialOut), .chipSelect_n(chipSelect_n),
    .serialClock(serialClock), .serialIn(serialIn));
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Frame helpers; reads keep the input busy with filler bytes
  task automatic frame(input logic [7:0] q[$]);
    host.select(1'b1);
    foreach (q[i])
      host.send_byte(q[i]);
    host.select(1'b0);
  endtask
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    frame('{{2'b01, a, 1'b0}, d[23:16], d[15:8], d[7:0]});
  endtask
  task automatic rd(input logic [4:0] a, output logic [23:0] d);
    frame('{{2'b00, a, 1'b0}, 8'hFF, 8'hFF, 8'hFF});
    d = host.rxHist[24:1];
  endtask
  task automatic fire(input logic [23:0] e);
    eventIn = e;
    wclk(1);
    eventIn = '0;
  endtask
  task automatic await_ready;
    wclk(150);
    check("early ready", 24'(readyFlag), 24'h00_0000);
    for (int i = 0; i < 500 && readyFlag !== 1'b1; i++)
      wclk(1);
    check("ready", 24'(readyFlag), 24'h00_0001);
  endtask
  // Expected pin level for {pulse-select, invert}
  function automatic logic irq_exp(input int m, input logic on);
    return on ? m[0] : !m[0];
  endfunction
  // Watchdog cuts a hang short
  initial
  begin
    #700us;
    nMismatch++;
    tally_and_finish;
  end
  initial
  begin
    wclk(5);
    rst_n = 1'b1;
    check("irq at reset", 24'(irqPin), 24'h00_0001);
    await_ready;
    repeat (4)
    begin
      idx = 5'(1 + $unsigned($random(seed)) % 14);
      ev = 24'($random(seed));
      wr(idx, ev);
      rd(idx, got);
      check("readback", got, ev);
    end
    frame('{{2'b00, idx, 1'b0}, 8'hA0, 8'hFF, 8'hFF});
    check("read past instr", host.rxHist[24:1], ev);
    frame('{{2'b00, idx, 1'b0}, 8'h00, 8'hFF, 8'hFF, 8'hFF});
    check("read restarted", host.rxHist[24:1], scep_pkg::CFG_RESET);
    frame('{8'hE8});
    frame('{8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'h00, 8'hFF, 8'hFF, 8'hFF});
    check("read after sync", host.rxHist[24:1], scep_pkg::CFG_RESET);
    check("run kept", 24'({computeRun, computeContinuous}), 24'h00_0003);
    frame('{8'hE0});
    check("single start", 24'({computeRun, computeContinuous}), 24'h00_0002);
    frame('{8'hA0});
    check("halt", 24'(computeRun), 24'h00_0000);
    frame('{8'h88});
    check("stand-by", 24'({powerStandby, powerSleep}), 24'h00_0002);
    frame('{8'hA0});
    check("wake", 24'({powerStandby, readyFlag}), 24'h00_0001);
    frame('{8'h90});
    check("sleep", 24'({powerStandby, powerSleep}), 24'h00_0001);
    frame('{8'hA0});
    wclk(600);
    check("sleep wake", 24'({powerSleep, readyFlag}), 24'h00_0001);
    // Every interrupt format: idle, raised, held, released
    wr(scep_pkg::IDX_MASK, 24'h00_0001);
    for (int m = 0; m < 4; m++)
    begin
      wr(scep_pkg::IDX_CONFIG, scep_pkg::CFG_RESET | (24'(m) << scep_pkg::CFG_POL_INV_BIT));
      wr(scep_pkg::IDX_STATUS, 24'hFF_FFFF);
      check("irq idle", 24'(irqPin), 24'(irq_exp(m, 1'b0)));
      fire(24'h00_0001);
      wclk(4);
      check("irq raised", 24'(irqPin), 24'(irq_exp(m, 1'b1)));
      wclk(24);
      check("irq held", 24'(irqPin), 24'(irq_exp(m, 1'b1)));
      if (m < 2)
        wr(scep_pkg::IDX_STATUS, 24'h00_0001);
      else
        wclk(80);
      check("irq released", 24'(irqPin), 24'(irq_exp(m, 1'b0)));
    end
    wr(scep_pkg::IDX_MASK, 24'h00_0000);
    ev = 24'($random(seed)) & 24'h7F_FFFF;
    fire(ev);
    wclk(4);
    check("masked irq", 24'(irqPin), 24'h00_0000);
    wr(scep_pkg::IDX_STATUS, 24'h00_0000);
    rd(scep_pkg::IDX_STATUS, got);
    // Bit zero is still set from the last pulse-format round, which never cleared it
    check("status kept", got & 24'h7F_FFFF, ev | 24'h00_0001);
    wr(scep_pkg::IDX_STATUS, got);
    rd(scep_pkg::IDX_STATUS, got);
    check("status cleared", got & 24'h7F_FFFF, 24'h00_0000);
    // Pin reset in mid-run, then software reset
    rst_n = 1'b0;
    wclk(2);
    check("pin reset", 24'({irqPin, readyFlag}), 24'h00_0002);
    rst_n = 1'b1;
    await_ready;
    wr(idx, ev);
    wr(scep_pkg::IDX_MASK, 24'h00_0003);
    frame('{8'h80});
    // Frozen clock enable: no crystal edge may count towards readiness
    clkEn = 1'b0;
    wclk(300);
    check("frozen", 24'(readyFlag), 24'h00_0000);
    clkEn = 1'b1;
    await_ready;
    rd(scep_pkg::IDX_MASK, got);
    check("mask default", got, scep_pkg::MASK_RESET);
    rd(idx, got);
    check("reg default", got, 24'h00_0000);
    check("irq default", 24'(irqPin), 24'h00_0001);
    tally_and_finish;
  end
endmodule
